// ### tmc_timer.sv
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// Operation
// - 16-bit counter clears, counts up or down
// - clock select zero stops counting; software writes still load it
// - software reads and writes counter any time
// - software counter write beats clear and count
// - high byte goes via holding register, except compare high byte reads
// - one holding register for all 16-bit registers
// - overflow flag set per mode, raises interrupt
// - qualified capture edge copies counter to capture
// - capture flag sets with the capture copy
// - capture flag interrupts, clears on service/one
// - capture low read loads holding register
// - capture writable only in capture-top modes
// - first instance may capture comparator output
// - source change may capture; software clears flag
// - filter output changes after four equal samples
// - filter enable bit, four cycles, system clock
// - no captures in capture-top modes
// - new capture overwrites unread capture value
// - pin sampled even when driven by port
module tmc_timer
   import tmc_pkg::*;
#(
   parameter bit HAS_COMPARATOR = 1'b1
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins
   input wire logic capture_pin,
   input wire logic comparator_output,
   input wire logic external_tick_pin,
   // interrupt requests and service acknowledges
   output logic ovf_irq,
   output logic cap_irq,
   input wire logic ovf_irq_ack,
   input wire logic cap_irq_ack
);

   // ********************************************************
   // helpers
   // ********************************************************
   function automatic logic icr_is_top(input logic [3:0] m);
      icr_is_top = m[3] & ~m[0];
   endfunction : icr_is_top

   function automatic logic [15:0] top_of(input logic [3:0] m,
                                          input logic [15:0] ocr,
                                          input logic [15:0] icr);
      case (m)
         4'h1, 4'h5: top_of = TOP_8;
         4'h2, 4'h6: top_of = TOP_9;
         4'h3, 4'h7: top_of = TOP_10;
         4'h4, 4'h9, 4'hB, 4'hF: top_of = ocr;
         4'h8, 4'hA, 4'hC, 4'hE: top_of = icr;
         default: top_of = MAX;
      endcase
   endfunction : top_of

   function automatic logic div_hit(input logic [PRE_W-1:0] p,
                                    input logic [PRE_W-1:0] m);
      div_hit = (p & m) == m;
   endfunction : div_hit

   // ********************************************************
   // state
   // ********************************************************
   tmc_ctrl_t ctrl_q;
   tmc_dir_t dir_q;
   tmc_dir_t dir_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] cap_q;
   logic [15:0] cmp_q;
   logic [7:0] temp_q;
   logic [PRE_W-1:0] pre_q;
   logic ovf_flag_q;
   logic cap_flag_q;
   logic ovf_en_q;
   logic cap_en_q;
   logic src_cmp_q;
   logic ext1_q;
   logic ext2_q;
   logic ext3_q;
   logic ack_q;
   logic [31:0] dat_q;

   // ********************************************************
   // bus decode
   // ********************************************************
   logic acc;
   logic wr;
   logic rd;
   logic [7:0] wbyte;
   logic cnt_wr_lo;
   logic cnt_rd_lo;
   logic cap_wr_lo;
   logic cap_rd_lo;
   logic cmp_wr_lo;
   logic hi_wr;
   logic flags_wr;

   assign acc = ce & wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr = acc & wb_we_i & wb_sel_i[0];
   assign rd = acc & ~wb_we_i;
   assign wbyte = wb_dat_i[7:0];
   assign cnt_wr_lo = wr & (wb_adr_i == OFS_CNT_LO);
   assign cnt_rd_lo = rd & (wb_adr_i == OFS_CNT_LO);
   assign cap_wr_lo = wr & (wb_adr_i == OFS_CAP_LO)
                      & icr_is_top(ctrl_q.wgm);
   assign cap_rd_lo = rd & (wb_adr_i == OFS_CAP_LO);
   assign cmp_wr_lo = wr & (wb_adr_i == OFS_CMP_LO);
   assign hi_wr = wr & (wb_adr_i == OFS_CNT_HI
                        || wb_adr_i == OFS_CAP_HI
                        || wb_adr_i == OFS_CMP_HI);
   assign flags_wr = wr & (wb_adr_i == OFS_FLAGS);

   // ********************************************************
   // timer tick
   // ********************************************************
   logic ext_rise;
   logic ext_fall;
   logic timer_tick;

   assign ext_rise = ext2_q & ~ext3_q;
   assign ext_fall = ~ext2_q & ext3_q;

   always_comb begin
      case (ctrl_q.cs)
         CS_STOP: timer_tick = 1'b0;
         CS_DIV1: timer_tick = 1'b1;
         CS_DIV8: timer_tick = div_hit(pre_q, DIV8_M);
         CS_DIV64: timer_tick = div_hit(pre_q, DIV64_M);
         CS_DIV256: timer_tick = div_hit(pre_q, DIV256_M);
         CS_DIV1024: timer_tick = div_hit(pre_q, DIV1024_M);
         CS_EXT_FALL: timer_tick = ext_fall;
         CS_EXT_RISE: timer_tick = ext_rise;
         default: timer_tick = 1'b0;
      endcase
   end

   // ********************************************************
   // counter unit
   // ********************************************************
   logic [15:0] top;
   logic dual;
   logic fast;
   logic plain;
   logic at_top;
   logic ovf_evt;

   assign top = top_of(ctrl_q.wgm, cmp_q, cap_q);
   assign dual = (ctrl_q.wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
                                     4'hA, 4'hB});
   assign fast = (ctrl_q.wgm inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});
   assign plain = (ctrl_q.wgm == 4'h0) || (ctrl_q.wgm == 4'hD);
   assign at_top = (cnt_q >= top);

   always_comb begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      ovf_evt = 1'b0;
      if (cnt_wr_lo) begin
         cnt_d = {temp_q, wbyte};
      end else if (ce && timer_tick) begin
         if (dual) begin
            if (dir_q == DIR_UP) begin
               dir_d = at_top ? DIR_DOWN : DIR_UP;
               cnt_d = at_top ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
            end else if (cnt_q == BOTTOM) begin
               dir_d = DIR_UP;
               cnt_d = cnt_q + 16'h0001;
               ovf_evt = 1'b1;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end else if (!plain && cnt_q == top) begin
            cnt_d = BOTTOM;
            ovf_evt = fast || (top == MAX);
         end else begin
            cnt_d = cnt_q + 16'h0001;
            ovf_evt = (cnt_q == MAX);
         end
      end
   end

   // ********************************************************
   // capture unit
   // ********************************************************
   logic cap_src;
   logic cap_edge;
   logic cap_evt;
   logic cap_clr;
   logic ovf_clr;

   // pin read straight, so driving it from the port still captures
   assign cap_src = (HAS_COMPARATOR && src_cmp_q) ? comparator_output
                                                  : capture_pin;

   tmc_capture_cond u_cond (
      .core_clk(core_clk),
      .srst(srst),
      .ce(ce),
      .raw_i(cap_src),
      .filt_en(ctrl_q.filt_en),
      .rise_sel(ctrl_q.edge_rise),
      .edge_o(cap_edge)
   );

   assign cap_evt = ce & cap_edge & ~icr_is_top(ctrl_q.wgm);
   assign cap_clr = cap_irq_ack | (flags_wr & wbyte[CAP_BIT]);
   assign ovf_clr = ovf_irq_ack | (flags_wr & wbyte[OVF_BIT]);
   assign ovf_irq = ovf_flag_q & ovf_en_q;
   assign cap_irq = cap_flag_q & cap_en_q;

   // ********************************************************
   // read data
   // ********************************************************
   logic [31:0] rdata;

   always_comb begin
      case (wb_adr_i)
         OFS_CTRL: rdata = {20'h00000, ctrl_q.wgm, ctrl_q.filt_en,
                            ctrl_q.edge_rise, 3'h0, ctrl_q.cs};
         OFS_CNT_LO: rdata = {24'h000000, cnt_q[7:0]};
         OFS_CAP_LO: rdata = {24'h000000, cap_q[7:0]};
         OFS_CMP_LO: rdata = {24'h000000, cmp_q[7:0]};
         OFS_CNT_HI, OFS_CAP_HI: rdata = {24'h000000, temp_q};
         OFS_CMP_HI: rdata = {24'h000000, cmp_q[15:8]};
         OFS_FLAGS: rdata = {30'h00000000, cap_flag_q, ovf_flag_q};
         OFS_IRQ_EN: rdata = {30'h00000000, cap_en_q, ovf_en_q};
         OFS_SRC_SEL: rdata = {31'h00000000, src_cmp_q};
         default: rdata = 32'h00000000;
      endcase
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ********************************************************
   // registers
   // ********************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
         pre_q <= '0;
         ext1_q <= 1'b0;
         ext2_q <= 1'b0;
         ext3_q <= 1'b0;
      end else if (ce) begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
         dat_q <= rd ? rdata : dat_q;
         pre_q <= pre_q + 10'h001;
         ext1_q <= external_tick_pin;
         ext2_q <= ext1_q;
         ext3_q <= ext2_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_q <= CNT_RST;
         dir_q <= DIR_UP;
      end else if (ce) begin
         cnt_q <= cnt_d;
         dir_q <= dir_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         temp_q <= TEMP_RST;
      end else if (hi_wr) begin
         temp_q <= wbyte;
      end else if (cnt_rd_lo) begin
         temp_q <= cnt_q[15:8];
      end else if (cap_rd_lo) begin
         temp_q <= cap_q[15:8];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cap_q <= CAP_RST;
         cmp_q <= CMP_RST;
      end else begin
         if (cap_wr_lo) begin
            cap_q <= {temp_q, wbyte};
         end else if (cap_evt) begin
            cap_q <= cnt_q;
         end
         if (cmp_wr_lo) begin
            cmp_q <= {temp_q, wbyte};
         end
      end
   end

   // set beats clear when both land in one cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ovf_flag_q <= 1'b0;
         cap_flag_q <= 1'b0;
      end else if (ce) begin
         ovf_flag_q <= ovf_evt | (ovf_flag_q & ~ovf_clr);
         cap_flag_q <= cap_evt | (cap_flag_q & ~cap_clr);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_q <= CTRL_RST;
         ovf_en_q <= 1'b0;
         cap_en_q <= 1'b0;
         src_cmp_q <= 1'b0;
      end else if (wr) begin
         if (wb_adr_i == OFS_CTRL) begin
            ctrl_q <= '{wb_dat_i[WGM_LSB+:4], wb_dat_i[FILT_BIT],
                        wb_dat_i[EDGE_BIT],
                        tmc_cs_t'(wb_dat_i[CS_LSB+:3])};
         end
         if (wb_adr_i == OFS_IRQ_EN) begin
            ovf_en_q <= wbyte[OVF_BIT];
            cap_en_q <= wbyte[CAP_BIT];
         end
         if (wb_adr_i == OFS_SRC_SEL) begin
            src_cmp_q <= wbyte[SRC_BIT] & HAS_COMPARATOR;
         end
      end
   end

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   stop_hold_a: assert property (
      (ctrl_q.cs == CS_STOP && !cnt_wr_lo) |=> $stable(cnt_q))
      else $error("counter moved with clock stopped");

   write_wins_a: assert property (
      cnt_wr_lo |=> cnt_q == $past({temp_q, wbyte}))
      else $error("counter write lost");

   temp_load_a: assert property (
      (cnt_rd_lo && !hi_wr) |=> temp_q == $past(cnt_q[15:8]))
      else $error("holding register not loaded from counter");

   cap_copy_a: assert property (
      cap_evt |=> cap_q == $past(cnt_q))
      else $error("capture did not copy counter");

   cap_flag_a: assert property (
      cap_evt |=> cap_flag_q && cap_q == $past(cnt_q))
      else $error("capture flag not set with capture");

   cap_clear_a: assert property (
      (ce && cap_clr && !cap_evt) |=> !cap_flag_q)
      else $error("capture flag did not clear");

   cap_guard_a: assert property (
      (wr && wb_adr_i == OFS_CAP_LO && !icr_is_top(ctrl_q.wgm)
       && !cap_evt) |=> $stable(cap_q))
      else $error("capture written outside capture-top mode");

   no_capture_a: assert property (
      icr_is_top(ctrl_q.wgm) |-> !cap_evt)
      else $error("capture in capture-top mode");

   ovf_set_a: assert property (
      ovf_evt |=> ovf_flag_q && (!ovf_en_q || ovf_irq))
      else $error("overflow flag not raised");

   sequence ack_once;
      ack_q ##1 !ack_q;
   endsequence

   ack_pulse_a: assert property (
      (ce && wb_cyc_i && wb_stb_i && !ack_q) |=> ack_once)
      else $error("bus answer not one cycle");

endmodule : tmc_timer

// ### tmc_pkg.sv
package tmc_pkg;

   // ********************************************************
   // register offsets, byte addresses on the bus
   // ********************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CNT_LO = 8'h04;
   localparam logic [7:0] OFS_CNT_HI = 8'h08;
   localparam logic [7:0] OFS_CAP_LO = 8'h0C;
   localparam logic [7:0] OFS_CAP_HI = 8'h10;
   localparam logic [7:0] OFS_CMP_LO = 8'h14;
   localparam logic [7:0] OFS_CMP_HI = 8'h18;
   localparam logic [7:0] OFS_FLAGS = 8'h1C;
   localparam logic [7:0] OFS_IRQ_EN = 8'h20;
   localparam logic [7:0] OFS_SRC_SEL = 8'h24;

   // ********************************************************
   // field positions
   // ********************************************************
   localparam int CS_LSB = 0;
   localparam int EDGE_BIT = 6;
   localparam int FILT_BIT = 7;
   localparam int WGM_LSB = 8;
   localparam int OVF_BIT = 0;
   localparam int CAP_BIT = 1;
   localparam int SRC_BIT = 0;

   // ********************************************************
   // reset values and fixed counter limits
   // ********************************************************
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CAP_RST = 16'h0000;
   localparam logic [15:0] CMP_RST = 16'h0000;
   localparam logic [7:0] TEMP_RST = 8'h00;
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [15:0] MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8 = 16'h00FF;
   localparam logic [15:0] TOP_9 = 16'h01FF;
   localparam logic [15:0] TOP_10 = 16'h03FF;

   // ********************************************************
   // timing counts
   // ********************************************************
   localparam int FILT_SAMPLES = 4;
   localparam int PRE_W = 10;
   localparam logic [PRE_W-1:0] DIV8_M = 10'h007;
   localparam logic [PRE_W-1:0] DIV64_M = 10'h03F;
   localparam logic [PRE_W-1:0] DIV256_M = 10'h0FF;
   localparam logic [PRE_W-1:0] DIV1024_M = 10'h3FF;

   // ********************************************************
   // types
   // ********************************************************
   typedef enum logic [2:0] {
      CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024,
      CS_EXT_FALL, CS_EXT_RISE
   } tmc_cs_t;

   typedef enum logic {DIR_UP, DIR_DOWN} tmc_dir_t;

   typedef struct packed {
      logic [3:0] wgm;
      logic filt_en;
      logic edge_rise;
      tmc_cs_t cs;
   } tmc_ctrl_t;

   localparam tmc_ctrl_t CTRL_RST = '{4'h0, 1'b0, 1'b0, CS_STOP};

endpackage : tmc_pkg

// ### tmc_capture_cond.sv
`timescale 1ns/1ns
module tmc_capture_cond
   import tmc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   // trigger input and setup
   input wire logic raw_i,
   input wire logic filt_en,
   input wire logic rise_sel,
   // qualified edge
   output logic edge_o
);

   logic sync1_q;
   logic sync2_q;
   logic [FILT_SAMPLES-1:0] hist_q;
   logic filt_q;
   logic filt_d;
   logic prev_q;
   logic all_same;

   // filter looks at history only, never at the first sync stage
   assign all_same = (&hist_q) | (~|hist_q);
   assign filt_d = filt_en ? (all_same ? hist_q[0] : filt_q)
                           : sync2_q;
   assign edge_o = rise_sel ? (filt_q & ~prev_q)
                            : (~filt_q & prev_q);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         hist_q <= '0;
         filt_q <= 1'b0;
         prev_q <= 1'b0;
      end else if (ce) begin
         sync1_q <= raw_i;
         sync2_q <= sync1_q;
         hist_q <= {hist_q[FILT_SAMPLES-2:0], sync2_q};
         filt_q <= filt_d;
         prev_q <= filt_q;
      end
   end

   filt_change_a: assert property (
      @(posedge core_clk) disable iff (srst)
      (ce && filt_en && filt_q != filt_d)
      |-> (hist_q == {FILT_SAMPLES{filt_d}}))
      else $error("filter output moved without four equal samples");

   edge_match_a: assert property (
      @(posedge core_clk) disable iff (srst)
      edge_o |-> (filt_q == rise_sel && prev_q != filt_q))
      else $error("edge reported against edge selection");

endmodule : tmc_capture_cond

// ### tmc_event_src.sv
`timescale 1ns/1ns
module tmc_event_src (
   // clock
   input wire logic core_clk,
   // event lines towards the timer
   output logic capture_pin,
   output logic comparator_output,
   output logic external_tick_pin
);

   // ****************************************
   // levels only change right after an edge
   // ****************************************
   initial begin
      capture_pin = 1'b0;
      comparator_output = 1'b0;
      external_tick_pin = 1'b0;
   end

   // lines are push-pull, so a level holds until the next change
   task automatic drive(input int sel, input logic lvl);
      case (sel)
         0: capture_pin <= lvl;
         1: comparator_output <= lvl;
         default: external_tick_pin <= lvl;
      endcase
   endtask : drive

   // short high times model glitches, long ones real events
   task automatic pulse(input int sel, input int hi, input int lo);
      drive(sel, 1'b1);
      repeat (hi) @(posedge core_clk);
      drive(sel, 1'b0);
      repeat (lo) @(posedge core_clk);
   endtask : pulse

endmodule : tmc_event_src

// ### tmc_timer_tb_top.sv
`timescale 1ns/1ns
module tmc_timer_tb_top
   import tmc_pkg::*;
;
   logic core_clk, srst, ce;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic capture_pin, comparator_output, external_tick_pin;
   logic ovf_irq, cap_irq, ovf_irq_ack, cap_irq_ack;
   int errors, check_count, n0, n1;

   tmc_timer #(.HAS_COMPARATOR(1'b1)) dut (
      .core_clk(core_clk), .srst(srst), .ce(ce),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .capture_pin(capture_pin), .comparator_output(comparator_output),
      .external_tick_pin(external_tick_pin),
      .ovf_irq(ovf_irq), .cap_irq(cap_irq),
      .ovf_irq_ack(ovf_irq_ack), .cap_irq_ack(cap_irq_ack));

   tmc_event_src src (
      .core_clk(core_clk), .capture_pin(capture_pin),
      .comparator_output(comparator_output),
      .external_tick_pin(external_tick_pin));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ****************************************
   // shared helpers
   // ****************************************
   task automatic wrap_up;
      if (errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // classic cycle; entered just after an edge
   task automatic wb_xfer(input logic we, input logic [7:0] adr,
                          input logic [15:0] wd, output logic [7:0] rd);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= {16'h0000, wd};
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge core_clk);
      if (n >= 50) begin
         errors++;
         wrap_up();
      end
   endtask : wb_xfer

   task automatic wr(input logic [7:0] adr, input logic [15:0] d);
      logic [7:0] unused;
      wb_xfer(1'b1, adr, d, unused);
   endtask : wr

   task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
      logic [7:0] v;
      wb_xfer(1'b0, adr, 16'h0000, v);
      chk({8'h00, v}, {8'h00, exp});
   endtask : rd

   task automatic set_ctrl(input logic [3:0] wgm, input logic filt,
                           input logic rise, input logic [2:0] cs);
      wr(OFS_CTRL, {4'h0, wgm, filt, rise, 3'b000, cs});
   endtask : set_ctrl

   task automatic set_cnt(input logic [15:0] v);
      wr(OFS_CNT_HI, {8'h00, v[15:8]});
      wr(OFS_CNT_LO, {8'h00, v[7:0]});
   endtask : set_cnt

   task automatic wait_cap(input int lim, output int n);
      n = 0;
      while (cap_irq !== 1'b1 && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      if (cap_irq !== 1'b1) begin
         chk({15'h0, cap_irq}, 16'h0001);
         wrap_up();
      end
   endtask : wait_cap

   // ****************************************
   // scenarios
   // ****************************************
   task automatic s_regs;
      chk({14'h0, ovf_irq, cap_irq}, 16'h0000);
      rd(OFS_CNT_LO, 8'h00);
      rd(OFS_CAP_LO, 8'h00);
      rd(OFS_FLAGS, 8'h00);
      rd(8'h3C, 8'h00);
   endtask : s_regs

   task automatic s_hold;
      set_ctrl(4'h0, 1'b0, 1'b0, 3'h0);
      set_cnt(16'h1234);
      repeat (20) @(posedge core_clk);
      rd(OFS_CNT_LO, 8'h34);
      rd(OFS_CNT_HI, 8'h12);
      wr(OFS_CNT_HI, 16'h00AB);
      wr(OFS_CNT_LO, 16'h0001);
      wr(OFS_CMP_LO, 16'h0002);
      rd(OFS_CMP_HI, 8'hAB);
      rd(OFS_CMP_LO, 8'h02);
      rd(OFS_CNT_LO, 8'h01);
      rd(OFS_CAP_HI, 8'hAB);
   endtask : s_hold

   task automatic s_tick;
      set_cnt(16'hFFFE);
      wr(OFS_FLAGS, 16'h0003);
      wr(OFS_IRQ_EN, 16'h0001);
      set_ctrl(4'h0, 1'b0, 1'b0, 3'h7);
      repeat (3) src.pulse(2, 4, 4);
      repeat (6) @(posedge core_clk);
      set_ctrl(4'h0, 1'b0, 1'b0, 3'h0);
      rd(OFS_CNT_LO, 8'h01);
      rd(OFS_CNT_HI, 8'h00);
      chk({15'h0, ovf_irq}, 16'h0001);
      ovf_irq_ack <= 1'b1;
      @(posedge core_clk);
      ovf_irq_ack <= 1'b0;
      @(posedge core_clk);
      chk({15'h0, ovf_irq}, 16'h0000);
   endtask : s_tick

   task automatic s_capture;
      set_ctrl(4'h0, 1'b0, 1'b1, 3'h0);
      set_cnt(16'h1234);
      wr(OFS_FLAGS, 16'h0003);
      wr(OFS_IRQ_EN, 16'h0002);
      src.drive(0, 1'b1);
      wait_cap(20, n0);
      chk({15'h0, cap_irq}, 16'h0001);
      rd(OFS_CAP_LO, 8'h34);
      rd(OFS_CAP_HI, 8'h12);
      wr(OFS_FLAGS, 16'h0002);
      chk({15'h0, cap_irq}, 16'h0000);
      set_cnt(16'h5678);
      src.drive(0, 1'b0);
      repeat (12) @(posedge core_clk);
      chk({15'h0, cap_irq}, 16'h0000);
      src.drive(0, 1'b1);
      wait_cap(20, n0);
      chk({15'h0, cap_irq}, 16'h0001);
      // value left unread on purpose
      set_cnt(16'h9ABC);
      set_ctrl(4'h0, 1'b0, 1'b0, 3'h0);
      wr(OFS_FLAGS, 16'h0002);
      src.drive(0, 1'b0);
      wait_cap(20, n0);
      rd(OFS_CAP_LO, 8'hBC);
      rd(OFS_CAP_HI, 8'h9A);
      cap_irq_ack <= 1'b1;
      @(posedge core_clk);
      cap_irq_ack <= 1'b0;
      @(posedge core_clk);
      chk({15'h0, cap_irq}, 16'h0000);
   endtask : s_capture

   task automatic s_filter;
      set_ctrl(4'h0, 1'b0, 1'b1, 3'h0);
      wr(OFS_FLAGS, 16'h0002);
      src.drive(0, 1'b1);
      wait_cap(20, n0);
      src.drive(0, 1'b0);
      set_ctrl(4'h0, 1'b1, 1'b1, 3'h0);
      repeat (10) @(posedge core_clk);
      wr(OFS_FLAGS, 16'h0002);
      src.pulse(0, 3, 15);
      chk({15'h0, cap_irq}, 16'h0000);
      src.drive(0, 1'b1);
      wait_cap(30, n1);
      chk(16'(n1), 16'(n0 + FILT_SAMPLES));
   endtask : s_filter

   task automatic s_source;
      set_ctrl(4'h0, 1'b0, 1'b1, 3'h0);
      wr(OFS_SRC_SEL, 16'h0001);
      wr(OFS_FLAGS, 16'h0002);
      set_cnt(16'h0042);
      src.pulse(0, 6, 12);
      chk({15'h0, cap_irq}, 16'h0000);
      src.drive(1, 1'b1);
      wait_cap(20, n0);
      chk({15'h0, cap_irq}, 16'h0001);
      rd(OFS_CAP_LO, 8'h42);
      wr(OFS_SRC_SEL, 16'h0000);
      wr(OFS_FLAGS, 16'h0002);
      chk({15'h0, cap_irq}, 16'h0000);
   endtask : s_source

   task automatic s_top;
      wr(OFS_CAP_HI, 16'h0077);
      wr(OFS_CAP_LO, 16'h0066);
      rd(OFS_CAP_LO, 8'h42);
      rd(OFS_CAP_HI, 8'h00);
      set_ctrl(4'hC, 1'b0, 1'b1, 3'h0);
      wr(OFS_CAP_HI, 16'h0003);
      wr(OFS_CAP_LO, 16'h0021);
      rd(OFS_CAP_LO, 8'h21);
      rd(OFS_CAP_HI, 8'h03);
      wr(OFS_FLAGS, 16'h0002);
      src.pulse(0, 6, 12);
      chk({15'h0, cap_irq}, 16'h0000);
      rd(OFS_CAP_LO, 8'h21);
   endtask : s_top

   // up/down mode at full rate; ce low must freeze the count
   task automatic s_modes;
      set_cnt(16'h00FE);
      set_ctrl(4'h1, 1'b0, 1'b0, 3'h1);
      ce <= 1'b0;
      repeat (5) @(posedge core_clk);
      ce <= 1'b1;
      set_ctrl(4'h1, 1'b0, 1'b0, 3'h0);
      rd(OFS_CNT_LO, 8'hFD);
      rd(OFS_CNT_HI, 8'h00);
   endtask : s_modes

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
      ovf_irq_ack = 1'b0;
      cap_irq_ack = 1'b0;
      errors = 0;
      check_count = 0;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      s_regs();
      s_hold();
      s_tick();
      s_capture();
      s_filter();
      s_source();
      s_top();
      s_modes();
      wrap_up();
   end

endmodule : tmc_timer_tb_top
